// >>> hdl/mas_sequencer.v
// Purpose: converter sequencing, averaging, result registers and limit checks
// Assumes: register port driven by the serial bus engine on mclk; adc_result valid at conversion end
// Notes:   register read data has one cycle latency
//
// Overview of operation
// - With timeout on, 35 ms without bus activity releases bus and aborts transfer.
// - Config one bit 6 clear (default) enables bus timeout; set disables it.
// - Results are 10 bits; nominal supply reads three-quarter scale, code 0x300.
// - Aux reading above high or below low limit sets status and may alert.
// - Each conversion takes 711 us; a measurement averages 16 conversions.
// - Config two bit 4 turns averaging off; each conversion is stored directly.
// - Config two bit 5 bypasses the aux supply input attenuator.
// - Config two bit 6 converts only the selected channel every conversion time.
// - Fan one minimum high byte bits 7:5 select the single-mode channel.
// - Local temperature upper eight bits go to 0x26, offset-64 or twos complement.
// - Normal range covers -63 to +127; extended reaches +191, quarter-degree steps.
// - Two low temperature bits stored in extended resolution register at 0x77.
// - Diode fault reads 1000 0000 in twos complement, all zeros in offset format.
`timescale 1ns/100ps
`include "mas_regs.vh"

module mas_sequencer #(
    parameter integer CONV_CYCLES    = (`MAS_CONV_TIME_NS / 1000) * `MAS_CLK_MHZ,
    parameter integer TIMEOUT_CYCLES = (`MAS_TIMEOUT_NS / 1000) * `MAS_CLK_MHZ
) (
    // clock and reset
    input  wire       mclk,
    input  wire       srst,
    // register port from the serial bus engine
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    // serial bus pins and timeout release
    input  wire       scl_pin,
    input  wire       sda_pin,
    output reg        bus_release,
    // analog converter
    output reg        adc_start,
    output reg  [2:0] adc_channel,
    output reg        adc_attn_bypass,
    input  wire [9:0] adc_result,
    input  wire       temp_diode_fault,
    input  wire       temp_extended_range,
    // status
    output reg        aux_high_status,
    output reg        aux_low_status,
    output reg        alert_n
);

    localparam [1:0] ST_IDLE  = 2'd0;
    localparam [1:0] ST_CONV  = 2'd1;
    localparam [1:0] ST_STORE = 2'd2;

    reg  [7:0]  aux_read_reg;
    reg  [7:0]  main_read_reg;
    reg  [7:0]  local_temp_reg;
    reg  [7:0]  cfg_one_reg;
    reg  [7:0]  cfg_two_reg;
    reg  [7:0]  aux_low_reg;
    reg  [7:0]  aux_high_reg;
    reg  [7:0]  fan_one_speed_min_hi_reg;
    reg  [7:0]  ext_res_two_reg;
    reg  [1:0]  state_reg;
    reg  [2:0]  chan_reg;
    reg  [31:0] conv_cnt_reg;
    reg  [3:0]  avg_cnt_reg;
    reg  [13:0] acc_reg;
    reg  [9:0]  result_next;
    reg  [7:0]  rdata_next;
    wire        release_pulse;
    wire        avg_off;
    wire        single_mode;
    wire [2:0]  sel_chan;
    wire [13:0] acc_sum;
    wire        acc_sign;
    wire [7:0]  reading_next;
    wire        aux_over;
    wire        aux_under;
    reg  [9:0]  conv_code;

    assign avg_off     = cfg_two_reg[`MAS_BIT_AVG_OFF];
    assign single_mode = cfg_two_reg[`MAS_BIT_SINGLE_CHAN];
    assign sel_chan    = fan_one_speed_min_hi_reg[`MAS_CHSEL_HI:`MAS_CHSEL_LO];

    // round-robin order over all channels
    function [2:0] mas_next_chan;
        input [2:0] cur;
        begin
            case (cur)
                `MAS_CH_AUX:     mas_next_chan = `MAS_CH_MAIN;
                `MAS_CH_MAIN:    mas_next_chan = `MAS_CH_REMOTE1;
                `MAS_CH_REMOTE1: mas_next_chan = `MAS_CH_LOCAL;
                `MAS_CH_LOCAL:   mas_next_chan = `MAS_CH_REMOTE2;
                default:         mas_next_chan = `MAS_CH_AUX;
            endcase
        end
    endfunction

    function mas_valid_chan;
        input [2:0] ch;
        begin
            mas_valid_chan = (ch == `MAS_CH_AUX) || (ch == `MAS_CH_MAIN) ||
                             (ch == `MAS_CH_REMOTE1) || (ch == `MAS_CH_LOCAL) ||
                             (ch == `MAS_CH_REMOTE2);
        end
    endfunction

    function mas_is_temp;
        input [2:0] ch;
        begin
            mas_is_temp = ch[2];
        end
    endfunction

    mas_bus_timeout #(
        .TIMEOUT_CYCLES (TIMEOUT_CYCLES)
    ) u_timeout (
        .mclk           (mclk),
        .srst           (srst),
        .scl_pin        (scl_pin),
        .sda_pin        (sda_pin),
        .timeout_enable (~cfg_one_reg[`MAS_BIT_TIMEOUT_DIS]),
        .bus_release    (release_pulse)
    );

    // temperature samples are twos complement quarter degrees
    always @* begin
        if (mas_is_temp(chan_reg) && temp_diode_fault)
            conv_code = temp_extended_range ? `MAS_FAULT_OFFSET : `MAS_FAULT_TWOS;
        else if (mas_is_temp(chan_reg) && temp_extended_range)
            conv_code = adc_result + `MAS_OFFSET64_CODE;
        else
            conv_code = adc_result;
    end

    // twos complement temperatures sum sign-extended so averages near zero stay right
    assign acc_sign = mas_is_temp(chan_reg) && !temp_extended_range && conv_code[9];
    assign acc_sum  = acc_reg + {{4{acc_sign}}, conv_code};

    // average or single result
    always @* begin
        if (avg_off)
            result_next = conv_code;
        else
            result_next = acc_sum[13:4];
    end

    // limit checks run on the 8-bit reading about to be stored
    assign reading_next = result_next[9:2];
    assign aux_over     = reading_next > aux_high_reg;
    assign aux_under    = reading_next < aux_low_reg;

    // register read decode
    always @* begin
        if (reg_addr == `MAS_ADDR_AUX_READ)
            rdata_next = aux_read_reg;
        else if (reg_addr == `MAS_ADDR_MAIN_READ)
            rdata_next = main_read_reg;
        else if (reg_addr == `MAS_ADDR_LOCAL_TEMP)
            rdata_next = local_temp_reg;
        else if (reg_addr == `MAS_ADDR_CFG_ONE)
            rdata_next = cfg_one_reg;
        else if (reg_addr == `MAS_ADDR_AUX_LOW)
            rdata_next = aux_low_reg;
        else if (reg_addr == `MAS_ADDR_AUX_HIGH)
            rdata_next = aux_high_reg;
        else if (reg_addr == `MAS_ADDR_FAN1_MIN_HI)
            rdata_next = fan_one_speed_min_hi_reg;
        else if (reg_addr == `MAS_ADDR_CFG_TWO)
            rdata_next = cfg_two_reg;
        else if (reg_addr == `MAS_ADDR_EXT_RES_TWO)
            rdata_next = ext_res_two_reg;
        else
            rdata_next = 8'h00;
    end

    // host writes
    // writes to read-only or unmapped offsets fall through and are dropped
    always @(posedge mclk) begin
        if (srst) begin
            cfg_one_reg              <= `MAS_RST_CFG_ONE;
            cfg_two_reg              <= `MAS_RST_CFG_TWO;
            aux_low_reg              <= `MAS_RST_AUX_LOW;
            aux_high_reg             <= `MAS_RST_AUX_HIGH;
            fan_one_speed_min_hi_reg <= `MAS_RST_FAN1_MIN_HI;
            reg_rdata                <= 8'h00;
            bus_release              <= 1'b0;
        end else begin
            reg_rdata   <= rdata_next;
            bus_release <= release_pulse;
            if (reg_wr) begin
                if (reg_addr == `MAS_ADDR_CFG_ONE)
                    cfg_one_reg <= reg_wdata;
                else if (reg_addr == `MAS_ADDR_CFG_TWO)
                    cfg_two_reg <= reg_wdata;
                else if (reg_addr == `MAS_ADDR_AUX_LOW)
                    aux_low_reg <= reg_wdata;
                else if (reg_addr == `MAS_ADDR_AUX_HIGH)
                    aux_high_reg <= reg_wdata;
                else if (reg_addr == `MAS_ADDR_FAN1_MIN_HI)
                    fan_one_speed_min_hi_reg <= reg_wdata;
            end
        end
    end

    // conversion sequencer
    always @(posedge mclk) begin
        if (srst) begin
            state_reg       <= ST_IDLE;
            chan_reg        <= `MAS_CH_AUX;
            conv_cnt_reg    <= 32'h0000_0000;
            avg_cnt_reg     <= 4'h0;
            acc_reg         <= 14'h0000;
            adc_start       <= 1'b0;
            adc_channel     <= `MAS_CH_AUX;
            adc_attn_bypass <= 1'b0;
            aux_read_reg    <= `MAS_RST_READING;
            main_read_reg   <= `MAS_RST_READING;
            local_temp_reg  <= `MAS_RST_READING;
            ext_res_two_reg <= 8'h00;
            aux_high_status <= 1'b0;
            aux_low_status  <= 1'b0;
            alert_n         <= 1'b1;
        end else begin
            adc_start <= 1'b0;
            alert_n   <= ~(aux_high_status | aux_low_status);
            case (state_reg)
                ST_IDLE: begin
                    if (single_mode) begin
                        if (mas_valid_chan(sel_chan)) begin
                            chan_reg    <= sel_chan;
                            adc_channel <= sel_chan;
                            adc_attn_bypass <= cfg_two_reg[`MAS_BIT_ATTN_BYPASS]
                                               && (sel_chan == `MAS_CH_AUX);
                            adc_start    <= 1'b1;
                            conv_cnt_reg <= 32'h0000_0000;
                            state_reg    <= ST_CONV;
                        end else begin
                            // unsupported selector code: no conversion, wait here
                            state_reg <= ST_IDLE;
                        end
                    end else begin
                        // scan mode: convert the current round-robin channel
                        adc_channel <= chan_reg;
                        adc_attn_bypass <= cfg_two_reg[`MAS_BIT_ATTN_BYPASS]
                                           && (chan_reg == `MAS_CH_AUX);
                        adc_start    <= 1'b1;
                        conv_cnt_reg <= 32'h0000_0000;
                        state_reg    <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    // converter busy; its result is taken in the store state
                    if (conv_cnt_reg == CONV_CYCLES - 1) begin
                        state_reg <= ST_STORE;
                    end else begin
                        conv_cnt_reg <= conv_cnt_reg + 32'h0000_0001;
                    end
                end
                ST_STORE: begin
                    if (avg_off || avg_cnt_reg == 4'hF) begin
                        avg_cnt_reg <= 4'h0;
                        acc_reg     <= 14'h0000;
                        case (chan_reg)
                            `MAS_CH_AUX: begin
                                aux_read_reg    <= reading_next;
                                aux_high_status <= aux_over;
                                aux_low_status  <= aux_under;
                            end
                            `MAS_CH_MAIN: begin
                                main_read_reg <= result_next[9:2];
                            end
                            `MAS_CH_LOCAL: begin
                                local_temp_reg <= result_next[9:2];
                                ext_res_two_reg[`MAS_EXT_LOCAL_LO +: 2] <= result_next[1:0];
                            end
                            `MAS_CH_REMOTE1: begin
                                ext_res_two_reg[`MAS_EXT_R1_LO +: 2] <= result_next[1:0];
                            end
                            default: begin
                                ext_res_two_reg[`MAS_EXT_R2_LO +: 2] <= result_next[1:0];
                            end
                        endcase
                        if (!single_mode)
                            chan_reg <= mas_next_chan(chan_reg);
                        state_reg <= ST_IDLE;
                    end else begin
                        // same channel again until sixteen conversions are summed
                        avg_cnt_reg  <= avg_cnt_reg + 4'h1;
                        acc_reg      <= acc_sum;
                        adc_start    <= 1'b1;
                        conv_cnt_reg <= 32'h0000_0000;
                        state_reg    <= ST_CONV;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // mas_sequencer

// >>> inc/mas_regs.vh
// Purpose: register map, field positions, reset values and timing for the monitor sequencer
// Assumes: 20 MHz mclk
// Notes:   definitions only
`ifndef MAS_REGS_VH
`define MAS_REGS_VH

// register offsets
`define MAS_ADDR_AUX_READ      8'h21
`define MAS_ADDR_MAIN_READ     8'h22
`define MAS_ADDR_LOCAL_TEMP    8'h26
`define MAS_ADDR_CFG_ONE       8'h40
`define MAS_ADDR_AUX_LOW       8'h46
`define MAS_ADDR_AUX_HIGH      8'h47
`define MAS_ADDR_FAN1_MIN_HI   8'h55
`define MAS_ADDR_CFG_TWO       8'h73
`define MAS_ADDR_EXT_RES_TWO   8'h77

// reset values
`define MAS_RST_READING        8'h00
`define MAS_RST_CFG_ONE        8'h00
`define MAS_RST_CFG_TWO        8'h00
`define MAS_RST_AUX_LOW        8'h00
`define MAS_RST_AUX_HIGH       8'hFF
`define MAS_RST_FAN1_MIN_HI    8'h00

// field positions
`define MAS_BIT_TIMEOUT_DIS    6
`define MAS_BIT_AVG_OFF        4
`define MAS_BIT_ATTN_BYPASS    5
`define MAS_BIT_SINGLE_CHAN    6
`define MAS_CHSEL_HI           7
`define MAS_CHSEL_LO           5
`define MAS_EXT_R1_LO          2
`define MAS_EXT_LOCAL_LO       4
`define MAS_EXT_R2_LO          6

// channel codes
`define MAS_CH_AUX             3'b001
`define MAS_CH_MAIN            3'b010
`define MAS_CH_REMOTE1         3'b101
`define MAS_CH_LOCAL           3'b110
`define MAS_CH_REMOTE2         3'b111

// conversion coding
`define MAS_NOMINAL_CODE       10'h300
`define MAS_FAULT_TWOS         10'h200
`define MAS_FAULT_OFFSET       10'h000
`define MAS_OFFSET64_CODE      10'h100
`define MAS_AVG_COUNT          16

// timing
`define MAS_CLK_MHZ            20
`define MAS_CONV_TIME_NS       711000
`define MAS_TIMEOUT_NS         35000000

`endif

// >>> hdl/mas_bus_timeout.v
// Purpose: serial bus inactivity watchdog
// Assumes: clock and data pins are asynchronous to mclk
// Notes:   release pulses once per idle stretch
`timescale 1ns/100ps
`include "mas_regs.vh"

module mas_bus_timeout #(
    parameter integer TIMEOUT_CYCLES = (`MAS_TIMEOUT_NS / 1000) * `MAS_CLK_MHZ
) (
    // clock and reset
    input  wire       mclk,
    input  wire       srst,
    // bus pins
    input  wire       scl_pin,
    input  wire       sda_pin,
    // control and result
    input  wire       timeout_enable,
    output reg        bus_release
);

    reg  [2:0]  scl_sync_reg;
    reg  [2:0]  sda_sync_reg;
    reg  [31:0] idle_cnt_reg;
    reg         fired_reg;
    reg         scl_stable_reg;
    reg         sda_stable_reg;
    wire        scl_chg;
    wire        sda_chg;

    // a pin change counts once the second and third stages agree
    assign scl_chg = (scl_sync_reg[1] == scl_sync_reg[2]) && (scl_sync_reg[2] != scl_stable_reg);
    assign sda_chg = (sda_sync_reg[1] == sda_sync_reg[2]) && (sda_sync_reg[2] != sda_stable_reg);

    always @(posedge mclk) begin
        if (srst) begin
            scl_sync_reg   <= 3'b111;
            sda_sync_reg   <= 3'b111;
            scl_stable_reg <= 1'b1;
            sda_stable_reg <= 1'b1;
            idle_cnt_reg   <= 32'h0000_0000;
            fired_reg      <= 1'b0;
            bus_release    <= 1'b0;
        end else begin
            scl_sync_reg <= {scl_sync_reg[1:0], scl_pin};
            sda_sync_reg <= {sda_sync_reg[1:0], sda_pin};
            if (scl_chg)
                scl_stable_reg <= scl_sync_reg[2];
            if (sda_chg)
                sda_stable_reg <= sda_sync_reg[2];
            bus_release <= 1'b0;
            if (scl_chg || sda_chg || !timeout_enable) begin
                idle_cnt_reg <= 32'h0000_0000;
                fired_reg    <= 1'b0;
            end else if (!fired_reg) begin
                if (idle_cnt_reg == TIMEOUT_CYCLES - 1) begin
                    bus_release <= 1'b1;
                    fired_reg   <= 1'b1;
                end else begin
                    idle_cnt_reg <= idle_cnt_reg + 32'h0000_0001;
                end
            end
        end
    end

endmodule // mas_bus_timeout

// >>> bench/mas_sequencer_properties.sv
// Purpose: port checks for the monitor sequencer
// Assumes: configuration is tracked from register writes
// Notes:   attached to every mas_sequencer by bind
`timescale 1ns/100ps
module mas_seq_props #(
    parameter integer CONV_CYCLES    = 20,
    parameter integer TIMEOUT_CYCLES = 200
) (
    // clock and reset
    input wire       mclk,
    input wire       srst,
    // register port
    input wire [7:0] reg_addr,
    input wire       reg_wr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    // outputs
    input wire       bus_release,
    input wire       adc_start,
    input wire [2:0] adc_channel,
    input wire       adc_attn_bypass,
    input wire       aux_high_status,
    input wire       aux_low_status,
    input wire       alert_n
);
    reg       tdis_reg;
    reg [7:0] cfg2_reg;
    reg [2:0] sel_reg;
    reg [9:0] gap_reg;
    reg [9:0] quiet_reg;
    reg       seen_reg;
    wire      cfg_wr = reg_wr && (reg_addr == 8'h73 || reg_addr == 8'h55);

    // mode changes land at a measurement boundary, so quiet_reg counts settled cycles
    always @(posedge mclk) begin
        if (srst) begin
            tdis_reg  <= 1'b0;
            cfg2_reg  <= 8'h00;
            sel_reg   <= 3'b000;
            gap_reg   <= 10'h000;
            quiet_reg <= 10'h000;
            seen_reg  <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == 8'h40)
                tdis_reg <= reg_wdata[6];
            if (reg_wr && reg_addr == 8'h73)
                cfg2_reg <= reg_wdata;
            if (reg_wr && reg_addr == 8'h55)
                sel_reg <= reg_wdata[7:5];
            gap_reg   <= adc_start ? 10'h000 : gap_reg + {9'h000, gap_reg != 10'h3ff};
            quiet_reg <= cfg_wr ? 10'h000 : quiet_reg + {9'h000, quiet_reg != 10'h3ff};
            seen_reg  <= seen_reg | adc_start;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    AST_RELEASE_ONE: assert property (bus_release |=> !bus_release)
        else $error("bus_release wider than one cycle");
    AST_TIMEOUT_OFF: assert property (tdis_reg && $past(tdis_reg, 4) |-> !bus_release)
        else $error("bus_release while timeout disabled");
    AST_START_GAP: assert property (adc_start && seen_reg |-> gap_reg >= CONV_CYCLES)
        else $error("conversion started too early");
    AST_ALERT: assert property (##1 alert_n == !($past(aux_high_status) || $past(aux_low_status)))
        else $error("alert_n does not follow status");
    AST_BYPASS_AUX: assert property (adc_attn_bypass |-> adc_channel == 3'b001)
        else $error("bypass on a channel other than aux");
    AST_BYPASS_SET: assert property (adc_start && adc_channel == 3'b001 && cfg2_reg[5]
        && quiet_reg > 10'd400 |-> adc_attn_bypass)
        else $error("bypass missing on aux");
    AST_CHAN_HOLD: assert property (adc_start |=> $stable(adc_channel) [*8])
        else $error("channel changed during conversion");
    AST_SINGLE_SEL: assert property (adc_start && cfg2_reg[6] && quiet_reg > 10'd400
        && sel_reg inside {3'b001, 3'b010, 3'b101, 3'b110, 3'b111}
        |-> adc_channel == sel_reg)
        else $error("single mode converts wrong channel");
    AST_SINGLE_REFUSE: assert property (adc_start && cfg2_reg[6] && quiet_reg > 10'd400
        |-> sel_reg inside {3'b001, 3'b010, 3'b101, 3'b110, 3'b111})
        else $error("single mode converts with an unsupported selector");
    AST_CFG_READBACK: assert property (reg_wr && reg_addr == 8'h73 ##1 !reg_wr
        && reg_addr == 8'h73 |=> reg_rdata == $past(reg_wdata, 2))
        else $error("configuration two readback wrong");
endmodule // mas_seq_props

bind mas_sequencer mas_seq_props #(.CONV_CYCLES(CONV_CYCLES), .TIMEOUT_CYCLES(TIMEOUT_CYCLES))
    u_props (.mclk, .srst, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .bus_release,
    .adc_start, .adc_channel, .adc_attn_bypass, .aux_high_status, .aux_low_status, .alert_n);

// >>> bench/mas_adc_model.sv
// Purpose: converter stand-in for the sequencer's analog side
// Assumes: result sampled CONV_CYCLES+1 edges after adc_start
// Notes:   aux code alternates by one lsb so averaging shows
`timescale 1ns/100ps
module mas_adc_model #(
    parameter integer CONV_CYCLES = 20
) (
    // clock and control
    input  wire       mclk,
    input  wire       adc_start,
    input  wire [2:0] adc_channel,
    // codes per channel
    input  wire [9:0] aux_code,
    input  wire [9:0] main_code,
    input  wire [9:0] temp_code,
    // result
    output reg  [9:0] adc_result = 10'h155
);
    integer cnt = 0;
    reg     odd = 1'b0;
    always @(posedge mclk) begin
        if (adc_start) begin
            cnt <= 0;
            odd <= odd ^ (adc_channel == 3'b001);
            adc_result <= adc_channel == 3'b001 ? aux_code + {9'h000, odd} :
                          adc_channel == 3'b010 ? main_code : temp_code;
        end else begin
            cnt <= cnt + 1;
            if (cnt == CONV_CYCLES)
                adc_result <= ~adc_result; // stale once the sample edge is past
        end
    end
endmodule // mas_adc_model

// >>> bench/testbench.sv
// Purpose: self-checking bench for the monitor sequencer
// Assumes: short conversion and timeout counts set below
// Notes:   register reads queue their expected byte for the read monitor
`timescale 1ns/100ps
module testbench;
    localparam integer CONV = 20;
    localparam integer TMO  = 200;
    localparam integer SCAN = 3600; // pending measurement plus a full scan
    reg         mclk = 1'b0, srst = 1'b1, reg_wr = 1'b0;
    reg         rd_req = 1'b0, rd_seen = 1'b0, scl_pin = 1'b1, sda_pin = 1'b1;
    reg         temp_diode_fault = 1'b0, temp_extended_range = 1'b0;
    reg  [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, r;
    reg  [9:0]  aux_code = 10'h003, temp_code = 10'h000, t0, code;
    wire [7:0]  reg_rdata;
    wire [2:0]  adc_channel;
    wire [9:0]  adc_result;
    wire        bus_release, adc_start, adc_attn_bypass, aux_high_status, aux_low_status, alert_n;
    reg  [15:0] exp_q[$];
    reg  [15:0] ent;
    reg  [15:0] rst_tab [0:9] = '{16'h2100, 16'h2200, 16'h2600, 16'h4000, 16'h4600,
                                  16'h47ff, 16'h5500, 16'h7300, 16'h7700, 16'h3000};
    reg  [2:0]  chan_tab [0:4] = '{3'b001, 3'b010, 3'b101, 3'b110, 3'b111};
    integer     bad_count = 0, total_checks = 0, rel_count = 0, cycles = 0, i;
    integer     start_count = 0;

    mas_sequencer #(.CONV_CYCLES(CONV), .TIMEOUT_CYCLES(TMO)) dut (
        .mclk, .srst, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .scl_pin, .sda_pin,
        .bus_release, .adc_start, .adc_channel, .adc_attn_bypass, .adc_result,
        .temp_diode_fault, .temp_extended_range, .aux_high_status, .aux_low_status, .alert_n);
    mas_adc_model #(.CONV_CYCLES(CONV)) adc (.mclk, .adc_start, .adc_channel, .aux_code,
        .main_code(10'h300), .temp_code, .adc_result);

    initial begin
        forever #25 mclk = ~mclk;
    end

    task check_byte(input string what, input [7:0] e, input [7:0] g);
        total_checks = total_checks + 1;
        if (g !== e) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task check_bit(input string what, input e, input g);
        check_byte(what, {7'h00, e}, {7'h00, g});
    endtask
    task wr(input [7:0] a, input [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
        @(negedge mclk);
    endtask
    task rd(input [7:0] a, input [7:0] e);
        reg_addr = a;
        exp_q.push_back({a, e});
        rd_req = 1'b1;
        @(negedge mclk);
        rd_req = 1'b0;
        @(negedge mclk);
    endtask
    task idle(input integer n);
        repeat (n) @(negedge mclk);
    endtask
    // link activity off the clock phase, ending on a stop
    task frame(input integer n);
        #7;
        repeat (2 * n) begin
            scl_pin = ~scl_pin;
            if (!scl_pin)
                sda_pin = 1'($urandom);
            #200;
        end
        sda_pin = 1'b1;
        @(negedge mclk);
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        rd_seen <= rd_req;
        if (bus_release)
            rel_count <= rel_count + 1;
        if (adc_start)
            start_count <= start_count + 1;
        if (cycles == 40000) begin
            bad_count = bad_count + 1;
            tally_and_finish;
        end
    end
    always @(negedge mclk) begin
        if (rd_seen) begin
            ent = exp_q.pop_front();
            check_byte($sformatf("reg_rdata at %h", ent[15:8]), ent[7:0], reg_rdata);
        end
    end

    initial begin
        void'($urandom(32'h9334));
        aux_code = {8'($urandom_range(254, 1)), 2'b11};
        temp_code = 10'($urandom_range(511, 0));
        t0 = temp_code;
        r = aux_code[9:2];
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        srst = 1'b0;
        wr(8'h21, 8'h5a);
        for (i = 0; i < 10; i = i + 1)
            rd(rst_tab[i][15:8], rst_tab[i][7:0]);
        $display("reset values done");
        idle(SCAN);
        rd(8'h21, r);
        rd(8'h22, 8'hc0);
        rd(8'h26, t0[9:2]);
        rd(8'h77, {t0[1:0], t0[1:0], t0[1:0], 2'b00});
        check_bit("alert_n", 1'b1, alert_n);
        $display("scan done");
        wr(8'h47, r - 8'h01);
        idle(SCAN);
        check_bit("aux_high_status", 1'b1, aux_high_status);
        check_bit("alert_n", 1'b0, alert_n);
        wr(8'h47, 8'hff);
        wr(8'h46, r + 8'h01);
        idle(SCAN);
        check_bit("aux_low_status", 1'b1, aux_low_status);
        check_bit("aux_high_status", 1'b0, aux_high_status);
        wr(8'h46, r);
        idle(SCAN);
        check_bit("alert_n", 1'b1, alert_n);
        $display("limits done");
        wr(8'h55, 8'hc0);
        wr(8'h73, 8'h50);
        for (i = 0; i < 4; i = i + 1) begin
            temp_extended_range = i[0];
            temp_diode_fault = i[1];
            if (i > 0)
                temp_code = 10'($urandom_range(511, 0));
            idle(i == 0 ? 400 : 60);
            code = i[1] ? (i[0] ? 10'h000 : 10'h200) : temp_code + (i[0] ? 10'h100 : 10'h000);
            rd(8'h26, code[9:2]);
            rd(8'h77, {t0[1:0], code[1:0], t0[1:0], 2'b00});
        end
        temp_diode_fault = 1'b0;
        for (i = 0; i < 5; i = i + 1) begin
            wr(8'h55, {chan_tab[i], 5'h00});
            idle(440);
            check_byte("adc_channel", {5'h00, chan_tab[i]}, {5'h00, adc_channel});
        end
        wr(8'h55, 8'h60);
        idle(60);
        start_count = 0;
        idle(100);
        check_byte("adc_start count", 8'h00, start_count[7:0]);
        wr(8'h55, 8'h20);
        wr(8'h73, 8'h60);
        idle(500);
        check_bit("adc_attn_bypass", 1'b1, adc_attn_bypass);
        rd(8'h73, 8'h60);
        $display("single channel done");
        rel_count = 0;
        frame(4);
        idle(560);
        check_byte("bus_release count", 8'h01, rel_count[7:0]);
        wr(8'h40, 8'h40);
        rel_count = 0;
        frame(4);
        idle(560);
        check_byte("bus_release count", 8'h00, rel_count[7:0]);
        wr(8'h40, 8'h00);
        rd(8'h40, 8'h00);
        $display("timeout done");
        tally_and_finish;
    end
endmodule // testbench
